//--- src/dlw_consts.svh
// Constants for the DLL switch and write leveling block.
// Assumes inclusion by bare name from the package and design files.
`ifndef DLW_CONSTS_SVH
`define DLW_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define DLW_OFF_MR1      8'h00
`define DLW_OFF_STATUS   8'h04
`define DLW_OFF_LEVEL    8'h08

// ----------------------------------------------------------------
// Field positions and MR1 reset value
// ----------------------------------------------------------------
`define DLW_MR1_DLL_DIS  0
`define DLW_MR1_RTT_LO   2
`define DLW_MR1_WLEV     7
`define DLW_MR1_QOFF     12
`define DLW_MR1_RESET    16'h0000
// Idle pin levels {cke, odt, upper strobe, lower strobe, ck}.
// CKE idles high so that leaving reset never looks like a self refresh entry.
`define DLW_SYNC_IDLE    5'h10

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DLW_CLK_PERIOD_NS 10
`define DLW_TCKSRE_NS     10
`define DLW_TCKSRE_CYC    ((`DLW_TCKSRE_NS + `DLW_CLK_PERIOD_NS - 1) / `DLW_CLK_PERIOD_NS)

`endif

//--- src/dlw_pkg.sv
// Types shared by the DLL switch and write leveling block.
// Assumes the constants header is on the include path.
package dlw_pkg;
    `include "dlw_consts.svh"

    // ------------------------------------------------------------
    // Bus carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } dlw_bus_req_type;

    typedef struct packed {
        logic        dqs_upper;
        logic        dqs_lower;
        logic        ck;
    } dlw_pins_type;

    typedef enum logic [1:0] {
        DLW_ST_NORMAL = 2'b00,
        DLW_ST_SREF   = 2'b01,
        DLW_ST_CKDC   = 2'b10
    } dlw_state_type;
endpackage

//--- src/dlw_lane_sampler.sv
// One byte lane of write leveling feedback.
// Assumes strobe and clock levels already synchronised to i_clk.
`timescale 1ns/100ps
module dlw_lane_sampler #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // Control
    input  wire logic             i_enable,
    input  wire logic             i_prime_only,
    // Synchronised pins
    input  wire logic             i_strobe,
    input  wire logic             i_ck,
    // Feedback
    output logic [WIDTH-1:0]      o_dq,
    output logic                  o_sample
);
    logic strobe_last;
    wire  strobe_rise = i_strobe & ~strobe_last;
    wire  next_sample = strobe_rise ? i_ck : o_sample;
    wire  [WIDTH-1:0] next_dq = i_prime_only ? {{(WIDTH-1){1'b0}}, next_sample}
                                             : {WIDTH{next_sample}};

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            strobe_last <= 1'b0;
            o_sample    <= 1'b0;
            o_dq        <= '0;
        end else begin
            strobe_last <= i_strobe;
            o_sample    <= i_enable ? next_sample : 1'b0;
            o_dq        <= i_enable ? next_dq : '0;
        end
    end
endmodule

//--- src/dlw_top.sv
// Device-side DLL mode, frequency change tracking and write leveling.
// Assumes an Avalon-MM master on i_clk and pins from outside the domain.
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/100ps
`include "dlw_consts.svh"

// Operation
// - MR1 A0 set disables DLL until cleared
// - After tcksre in self refresh, clock ignored
// - Leveling samples clock on strobe rise
// - Device terminates strobes, controller terminates data
// - x16 gives separate feedback per byte lane
// - MR1 A7 enters leveling, clear exits
module dlw_top #(
    parameter int LANE_W = 8
) (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    // Avalon-MM slave
    input  wire dlw_pkg::dlw_bus_req_type i_avs,
    output logic [31:0]                 o_avs_readdata,
    output logic                        o_avs_waitrequest,
    // Device pins
    input  wire logic                   i_cke,
    input  wire logic                   i_odt,
    input  wire dlw_pkg::dlw_pins_type  i_pins,
    // Leveling feedback and termination
    output logic [2*LANE_W-1:0]         o_dq,
    output logic [2*LANE_W-1:0]         o_dq_oe,
    output logic                        o_strobe_term,
    // Status
    output logic                        o_dll_enabled,
    output logic                        o_clock_ignored
);
    import dlw_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync1;
    logic [4:0] sync2;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1 <= `DLW_SYNC_IDLE;
            sync2 <= `DLW_SYNC_IDLE;
        end else begin
            sync1 <= {i_cke, i_odt, i_pins.dqs_upper, i_pins.dqs_lower, i_pins.ck};
            sync2 <= sync1;
        end
    end
    wire cke_s = sync2[4];
    wire odt_s = sync2[3];
    wire dqsu_s = sync2[2];
    wire dqsl_s = sync2[1];
    wire ck_s = sync2[0];

    // ------------------------------------------------------------
    // Mode register 1 and bus decode
    // ------------------------------------------------------------
    logic [15:0]   mr1;
    logic          ack;
    dlw_state_type state;
    logic [7:0]    tcnt;

    wire req     = i_avs.read | i_avs.write;
    wire hit_mr1 = i_avs.address == `DLW_OFF_MR1;
    wire hit_st  = i_avs.address == `DLW_OFF_STATUS;
    wire hit_lev = i_avs.address == `DLW_OFF_LEVEL;
    wire wr_mr1  = i_avs.write & ack & hit_mr1;
    wire dll_dis = mr1[`DLW_MR1_DLL_DIS];
    wire wlev    = mr1[`DLW_MR1_WLEV];
    wire qoff    = mr1[`DLW_MR1_QOFF];

    logic [2*LANE_W-1:0] lane_dq;
    logic                samp_u;
    logic                samp_l;

    wire [31:0] rd_st  = {28'h000_0000, 1'b0, state == DLW_ST_CKDC, state != DLW_ST_NORMAL,
                          ~dll_dis};
    wire [31:0] rd_lev = {30'h0000_0000, samp_u, samp_l};
    wire [31:0] next_rd = hit_mr1 ? {16'h0000, mr1} :
                          hit_st  ? rd_st :
                          hit_lev ? rd_lev : 32'h0000_0000;

    // One wait cycle: the answer comes the edge after the request is seen.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0000_0000;
        end else begin
            o_avs_waitrequest <= ~(req & o_avs_waitrequest);
            o_avs_readdata    <= next_rd;
        end
    end
    assign ack = ~o_avs_waitrequest;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mr1 <= `DLW_MR1_RESET;
        end else if (wr_mr1) begin
            mr1 <= i_avs.writedata[15:0];
        end
    end

    // ------------------------------------------------------------
    // Self refresh tracking: CKE low enters, clock ignored after tcksre
    // ------------------------------------------------------------
    localparam logic [7:0] TCKSRE = 8'(`DLW_TCKSRE_CYC);
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= DLW_ST_NORMAL;
            tcnt  <= 8'h00;
        end else begin
            case (state)
                DLW_ST_NORMAL: begin
                    tcnt <= 8'h00;
                    if (!cke_s) begin
                        state <= DLW_ST_SREF;
                    end
                end
                DLW_ST_SREF: begin
                    tcnt <= tcnt + 8'h01;
                    if (cke_s) begin
                        state <= DLW_ST_NORMAL;
                    end else if (tcnt + 8'h01 >= TCKSRE) begin
                        state <= DLW_ST_CKDC;
                    end
                end
                default: begin
                    if (cke_s) begin
                        state <= DLW_ST_NORMAL;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Write leveling feedback, one sampler per byte lane
    // ------------------------------------------------------------
    dlw_lane_sampler #(.WIDTH(LANE_W)) u_lower (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_enable     (wlev & ~qoff),
        .i_prime_only (1'b0),
        .i_strobe     (dqsl_s),
        .i_ck         (ck_s),
        .o_dq         (lane_dq[LANE_W-1:0]),
        .o_sample     (samp_l)
    );
    dlw_lane_sampler #(.WIDTH(LANE_W)) u_upper (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_enable     (wlev & ~qoff),
        .i_prime_only (1'b0),
        .i_strobe     (dqsu_s),
        .i_ck         (ck_s),
        .o_dq         (lane_dq[2*LANE_W-1:LANE_W]),
        .o_sample     (samp_u)
    );

    // Output registers; termination only follows ODT while leveling.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_dq            <= '0;
            o_dq_oe         <= '0;
            o_strobe_term   <= 1'b0;
            o_dll_enabled   <= 1'b1;
            o_clock_ignored <= 1'b0;
        end else begin
            o_dq            <= lane_dq;
            o_dq_oe         <= {(2*LANE_W){wlev & ~qoff}};
            o_strobe_term   <= wlev & odt_s;
            o_dll_enabled   <= ~dll_dis;
            o_clock_ignored <= state == DLW_ST_CKDC;
        end
    end
endmodule

//--- dv/dlw_top_checker.sv
// Assertions on the ports of the DLL switch and leveling block.
// Assumes it is bound to dlw_top and sees only its ports.
`timescale 1ns/100ps
module dlw_top_checker #(
    parameter int LANE_W = 8
) (
    // Watched ports
    input wire logic                     i_clk,
    input wire logic                     i_rst,
    input wire dlw_pkg::dlw_bus_req_type i_avs,
    input wire logic                     i_cke,
    input wire logic                     i_odt,
    input wire dlw_pkg::dlw_pins_type    i_pins,
    input wire logic [2*LANE_W-1:0]      o_dq,
    input wire logic [2*LANE_W-1:0]      o_dq_oe,
    input wire logic                     o_strobe_term,
    input wire logic                     o_dll_enabled,
    input wire logic                     o_clock_ignored
);
    import dlw_pkg::*;
    // ----
    // Properties
    // ----
    localparam int U = 2*LANE_W-1;
    wire mw     = i_avs.write && i_avs.address == 8'h00;
    wire dis_wr = mw && i_avs.writedata[0];
    wire en_wr  = mw && !i_avs.writedata[0];
    wire lv_wr  = mw && i_avs.writedata[7] && !i_avs.writedata[12];
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_dll_off: assert property ($fell(o_dll_enabled)
        |-> $past(dis_wr) || $past(dis_wr, 2)) else $error("dll off without write");
    a_dll_on: assert property ($rose(o_dll_enabled)
        |-> $past(en_wr) || $past(en_wr, 2)) else $error("dll on without write");
    a_oe_by_write: assert property ($rose(o_dq_oe[0])
        |-> $past(lv_wr) || $past(lv_wr, 2)) else $error("leveling without write");
    a_sref_ignored: assert property ((!i_cke)[*8] |-> o_clock_ignored)
        else $error("clock not ignored in self refresh");
    a_upper_sample: assert property (o_dq_oe[U] && $rose(i_pins.dqs_upper)
        ##1 ($stable(i_pins.ck) && o_dq_oe[U])[*6] |-> o_dq[U] == i_pins.ck)
        else $error("upper lane feedback wrong");
    a_lower_sample: assert property (o_dq_oe[0] && $rose(i_pins.dqs_lower)
        ##1 ($stable(i_pins.ck) && o_dq_oe[0])[*6] |-> o_dq[0] == i_pins.ck)
        else $error("lower lane feedback wrong");
    a_term_on: assert property ((o_dq_oe[0] && i_odt)[*5] |-> o_strobe_term)
        else $error("strobe not terminated");
    a_term_off: assert property ((!i_odt)[*5] |-> !o_strobe_term)
        else $error("strobe terminated with odt low");
endmodule

bind dlw_top dlw_top_checker #(.LANE_W(LANE_W)) dlw_top_checker_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_avs(i_avs), .i_cke(i_cke), .i_odt(i_odt),
    .i_pins(i_pins), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_strobe_term(o_strobe_term),
    .o_dll_enabled(o_dll_enabled), .o_clock_ignored(o_clock_ignored));

//--- dv/dlw_ctrl_model.sv
// Controller side model driving CKE, ODT, clock level and strobes.
// Assumes its tasks are called from the bench in sequence.
`timescale 1ns/100ps
module dlw_ctrl_model (
    // Clock
    input  wire logic             i_clk,
    // Pins toward the device
    output logic                  o_cke,
    output logic                  o_odt,
    output dlw_pkg::dlw_pins_type o_pins
);
    import dlw_pkg::*;
    // ----
    // Pin sequences
    // ----
    // Idle with termination off, so mode writes are legal from the start.
    initial begin
        o_cke  = 1'b1;
        o_odt  = 1'b0;
        o_pins = '0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // The clock level moves only once the device ignores it.
    task automatic sref_enter();
        @(posedge i_clk);
        o_cke <= 1'b0;
        hold(4);
        repeat (6) begin
            o_pins.ck <= ~o_pins.ck;
            hold(1);
        end
        hold(3);
    endtask
    task automatic sref_exit();
        @(posedge i_clk);
        o_cke <= 1'b1;
        hold(8);
    endtask
    task automatic set_odt(input logic v);
        @(posedge i_clk);
        o_odt <= v;
        hold(6);
    endtask
    // The clock level settles before the strobe rises, as sync lags both.
    task automatic strobe(input logic up, input logic lvl);
        @(posedge i_clk);
        o_pins.ck <= lvl;
        hold(2);
        if (up) o_pins.dqs_upper <= 1'b1;
        else o_pins.dqs_lower <= 1'b1;
        hold(8);
        o_pins.dqs_upper <= 1'b0;
        o_pins.dqs_lower <= 1'b0;
        hold(2);
    endtask
endmodule

//--- dv/tb_dlw_top.sv
// Self-checking bench for dlw_top over its Avalon-MM slave.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
module tb_dlw_top;
    import dlw_pkg::*;
    logic            i_clk;
    logic            i_rst;
    dlw_bus_req_type avs;
    logic [31:0]     rd;
    logic [31:0]     q;
    logic            cke, odt, wreq, term, dll_on, ign;
    dlw_pins_type    pins;
    logic [15:0]     dq, dq_oe;
    int              miscompares = 0;
    int              cmp_count = 0;
    dlw_top dlw_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_avs(avs), .o_avs_readdata(rd),
        .o_avs_waitrequest(wreq), .i_cke(cke), .i_odt(odt), .i_pins(pins), .o_dq(dq),
        .o_dq_oe(dq_oe), .o_strobe_term(term), .o_dll_enabled(dll_on),
        .o_clock_ignored(ign));
    dlw_ctrl_model dlw_ctrl_model_inst (.i_clk(i_clk), .o_cke(cke), .o_odt(odt), .o_pins(pins));
    // ----
    // Tasks
    // ----
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        avs <= '{a, !wr, wr, d};
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (wreq !== 1'b0) begin
            miscompares++;
            final_report();
        end
        q = rd;
        avs <= '0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string w);
        bus(1'b0, a, 32'h0000_0000);
        chk(w, e, q);
    endtask
    task automatic settle();
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
    endtask
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        i_rst = 1'b1;
        avs   = '0;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        rdchk(8'h00, 32'h0000_0000, "mr1 reset");
        rdchk(8'h04, 32'h0000_0001, "status reset");
        bus(1'b1, 8'h0C, 32'h0000_FFFF);
        rdchk(8'h0C, 32'h0000_0000, "unmapped");
        bus(1'b1, 8'h04, 32'h0000_0007);
        rdchk(8'h04, 32'h0000_0001, "status read only");
        bus(1'b1, 8'h00, 32'hFFFF_0001);
        bus(1'b1, 8'h00, 32'hFFFF_0001);
        rdchk(8'h00, 32'h0000_0001, "mr1 copy");
        settle();
        chk("dll pin", 32'h0000_0000, {31'h0, dll_on});
        dlw_ctrl_model_inst.sref_enter();
        chk("ignored pin", 32'h0000_0001, {31'h0, ign});
        rdchk(8'h04, 32'h0000_0006, "in self refresh");
        dlw_ctrl_model_inst.sref_exit();
        chk("ignored pin off", 32'h0000_0000, {31'h0, ign});
        rdchk(8'h04, 32'h0000_0000, "after exit");
        bus(1'b1, 8'h00, 32'h0000_0000);
        rdchk(8'h04, 32'h0000_0001, "dll back");
        settle();
        chk("dll pin on", 32'h0000_0001, {31'h0, dll_on});
        bus(1'b1, 8'h00, 32'h0000_0080);
        dlw_ctrl_model_inst.set_odt(1'b1);
        settle();
        chk("dq enable", 32'h0000_FFFF, {16'h0, dq_oe});
        chk("strobe term", 32'h0000_0001, {31'h0, term});
        dlw_ctrl_model_inst.strobe(1'b1, 1'b0);
        settle();
        chk("upper low", 32'h0000_0000, {16'h0, dq});
        dlw_ctrl_model_inst.strobe(1'b1, 1'b1);
        settle();
        chk("upper high", 32'h0000_FF00, {16'h0, dq});
        dlw_ctrl_model_inst.strobe(1'b0, 1'b1);
        settle();
        chk("lower high", 32'h0000_FFFF, {16'h0, dq});
        dlw_ctrl_model_inst.strobe(1'b1, 1'b0);
        settle();
        chk("upper apart", 32'h0000_00FF, {16'h0, dq});
        rdchk(8'h08, 32'h0000_0001, "sample reg");
        bus(1'b1, 8'h00, 32'h0000_1080);
        settle();
        chk("outputs off", 32'h0000_0000, {16'h0, dq_oe});
        chk("dq off", 32'h0000_0000, {16'h0, dq});
        dlw_ctrl_model_inst.set_odt(1'b0);
        bus(1'b1, 8'h00, 32'h0000_0000);
        settle();
        chk("term off", 32'h0000_0000, {31'h0, term});
        final_report();
    end
endmodule
